// ==== pulse_partner.sv ====
/*
 Far-side model: timer 2 pin pulse source and timer 0/1 overflow pulses.
 Assumes the hclk domain; the pin stands high outside bursts.
*/
`timescale 1ns/100ps
module pulse_partner #(
    parameter int PIN_HALF = 2,
    parameter int GAP0 = 10,
    parameter int GAP1 = 6
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pin_run,
    input wire logic ovf_run,
    output logic timer2_pin_in,
    output logic timer0_overflow,
    output logic timer1_overflow
);
    int pc;
    int c0;
    int c1;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc <= 0;
            timer2_pin_in <= 1'b1;
        end else if (!pin_run) begin
            pc <= 0;
            timer2_pin_in <= 1'b1;
        end else begin
            pc <= (pc == 2 * PIN_HALF - 1) ? 0 : pc + 1;
            timer2_pin_in <= (pc < PIN_HALF) ? 1'b0 : 1'b1;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            c0 <= 0;
            c1 <= 0;
            timer0_overflow <= 1'b0;
            timer1_overflow <= 1'b0;
        end else begin
            c0 <= (ovf_run && c0 < GAP0 - 1) ? c0 + 1 : 0;
            c1 <= (ovf_run && c1 < GAP1 - 1) ? c1 + 1 : 0;
            timer0_overflow <= ovf_run && (c0 == GAP0 - 1);
            timer1_overflow <= ovf_run && (c1 == GAP1 - 1);
        end
    end
endmodule

// ==== tick_prescaler.sv ====
/*
 Tick prescaler: one-cycle tick every DIV clocks, or every clock in bypass.
 Assumes enable and bypass come from logic on the same clock.
*/
`timescale 1ns/100ps
`include "timer2_regs.svh"
module tick_prescaler #(
    parameter int DIV = `PRESCALE_DIV
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic enable,
    input wire logic bypass,
    output logic tick
);
    logic [3:0] phase;
    localparam logic [3:0] LAST = 4'(DIV - 1);

    // Restarting on stop keeps the first tick a full period after start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= 4'h0;
        end else if (!enable || bypass || phase == LAST) begin
            phase <= 4'h0;
        end else begin
            phase <= phase + 4'h1;
        end
    end

    assign tick = enable && (bypass || phase == LAST);

    // Independent count of cycles since the last divided tick
    logic [3:0] gap;
    logic gap_valid;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap <= 4'h0;
            gap_valid <= 1'b0;
        end else if (!enable || bypass) begin
            gap <= 4'h0;
            gap_valid <= 1'b0;
        end else if (tick) begin
            gap <= 4'h0;
            gap_valid <= 1'b1;
        end else begin
            gap <= gap + 4'h1;
        end
    end

    // (R03) divided tick spacing
    AST_SLOW_PERIOD: assert property ( // R03
        @(posedge hclk) disable iff (!hresetn)
        tick && !bypass && gap_valid |-> gap == LAST)
        else $error("slow tick spacing differs from the divide ratio");
endmodule

// ==== timer2_clkout.sv ====
/*
 Timer 2 auto-reload counter with hidden reload, clock outputs for
 timers 0, 1 and 2, second interrupt-enable register, AHB-Lite slave.
 Assumes timer 0 and 1 overflow pulses come from logic on hclk, and the
 timer 2 pin input is asynchronous.
*/
// Overview of operation
// (R01) Timer 2 counts only while the run bit is one; otherwise holds.
// (R02) Select bit chooses internal clock ticks or external pin pulses.
// (R03) Timer mode advances every twelve clocks, or every clock when fast.
// (R04) Count writes while stopped load counter and hidden reload together.
// (R05) Count writes while running load only the hidden reload byte.
// (R06) Reading count addresses returns the live counter, never the reload.
// (R07) Overflow sets the request flag and reloads; reload keeps its value.
// (R08) Timer 2 clock-out enable drives pin with half the overflow rate.
// (R09) Timer mode output is clock, over twelve if slow, over span, halved.
// (R10) Counter mode output is pin rate over reload span, halved.
// (R11) Timer 0 clock-out enable drives its pin at half overflow rate.
// (R12) Timer 0 sixteen-bit reload output is counted clock over span, halved.
// (R13) Timer 0 eight-bit reload output is counted clock over byte span, halved.
// (R14) Timer 1 clock-out enable drives its pin at half overflow rate.
// (R15) Timer 1 output is counted clock over its reload span, halved.
// (R16) Second interrupt-enable register holds seven per-source enable bits.
// (R17) Software leaves a clock-producing timer's interrupt disabled.
// (R18) Each enabled clock output toggles once per selected overflow.
`timescale 1ns/100ps
`include "timer2_regs.svh"
module timer2_clkout (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic timer2_pin_in,
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    output logic timer2_clk_out,
    output logic timer2_clk_oe,
    output logic timer0_clk_out,
    output logic timer0_clk_oe,
    output logic timer1_clk_out,
    output logic timer1_clk_oe,
    output logic timer0_fast_tick,
    output logic timer1_fast_tick,
    output logic [7:0] interrupt_enable_second,
    output logic timer2_irq_request,
    output logic irq
);
    timer2_pkg::bus_state_t bus_state;
    logic [7:0] auxiliary_control;
    logic [7:0] clock_output_and_extint_enable;
    logic [15:0] count;
    logic [15:0] reload;
    logic [`STAT_WIDTH-1:0] irq_status;
    logic [`STAT_WIDTH-1:0] irq_mask;
    logic [7:0] dp_idx;
    logic wr_pend;
    logic take;
    logic wr_en;
    logic [7:0] next_rdata;
    logic timer2_run;
    logic timer2_counter_select;
    logic timer2_fast_tick;
    logic prescale_tick;
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic pin_fall;
    logic tick;
    logic t2_overflow;
    logic wr_low;
    logic wr_high;
    logic [`STAT_WIDTH-1:0] stat_events;
    logic [`STAT_WIDTH-1:0] stat_clear;
    logic [`CLKO_CHANNELS-1:0] chan_ovf;
    logic [`CLKO_CHANNELS-1:0] chan_en;
    logic [`CLKO_CHANNELS-1:0] chan_level;
    logic [`CLKO_CHANNELS-1:0] chan_oe;

    // Bus slave
    assign take = hsel && htrans[1] && hready;
    assign hresp = 1'b0;
    assign hreadyout = (bus_state != timer2_pkg::BUS_RD_WAIT);
    assign wr_en = wr_pend;

    // Reads take one wait state so a write just before is already visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= timer2_pkg::BUS_IDLE;
            wr_pend <= 1'b0;
            dp_idx <= 8'h00;
        end else begin
            case (bus_state)
                timer2_pkg::BUS_IDLE: begin
                    wr_pend <= take && hwrite;
                    if (take) begin
                        dp_idx <= haddr[`IDX_MSB:`IDX_LSB];
                    end
                    if (take && !hwrite) begin
                        bus_state <= timer2_pkg::BUS_RD_WAIT;
                    end
                end
                timer2_pkg::BUS_RD_WAIT: begin
                    wr_pend <= 1'b0;
                    bus_state <= timer2_pkg::BUS_IDLE;
                end
                default: begin
                    wr_pend <= 1'b0;
                    bus_state <= timer2_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // Read mux
    always_comb begin
        next_rdata = 8'h00;
        case (dp_idx)
            `IDX_AUX_CONTROL: next_rdata = auxiliary_control;
            `IDX_CLKOUT_EXTINT: next_rdata = clock_output_and_extint_enable;
            `IDX_IE_SECOND: next_rdata = interrupt_enable_second;
            // (R06) live count read
            `IDX_T2_HIGH: next_rdata = count[15:8];
            `IDX_T2_LOW: next_rdata = count[7:0];
            `IDX_IRQ_STATUS: next_rdata = {5'h00, irq_status};
            `IDX_IRQ_MASK: next_rdata = {5'h00, irq_mask};
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (bus_state == timer2_pkg::BUS_RD_WAIT) begin
            hrdata <= {24'h00_0000, next_rdata};
        end
    end

    // Control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            auxiliary_control <= `RST_AUX;
        end else if (wr_en && dp_idx == `IDX_AUX_CONTROL) begin
            auxiliary_control <= hwdata[7:0];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clock_output_and_extint_enable <= `RST_CLKOUT;
        end else if (wr_en && dp_idx == `IDX_CLKOUT_EXTINT) begin
            clock_output_and_extint_enable <= hwdata[7:0] & `MASK_CLKOUT;
        end
    end
    // (R16) second enable register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            interrupt_enable_second <= `RST_IE2;
        end else if (wr_en && dp_idx == `IDX_IE_SECOND) begin
            interrupt_enable_second <= hwdata[7:0] & `MASK_IE2;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask <= `RST_STAT;
        end else if (wr_en && dp_idx == `IDX_IRQ_MASK) begin
            irq_mask <= hwdata[`STAT_WIDTH-1:0];
        end
    end
    assign timer2_run = auxiliary_control[`BIT_T2_RUN];
    assign timer2_counter_select = auxiliary_control[`BIT_T2_CSEL];
    assign timer2_fast_tick = auxiliary_control[`BIT_T2_FAST];
    assign timer0_fast_tick = auxiliary_control[`BIT_T0_FAST];
    assign timer1_fast_tick = auxiliary_control[`BIT_T1_FAST];

    // Pin synchroniser and falling-edge detect
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            pin_meta <= timer2_pin_in;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign pin_fall = pin_prev && !pin_sync;

    // (R03) divide by twelve or one
    tick_prescaler #(
        .DIV(`PRESCALE_DIV)
    ) u_prescaler (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(timer2_run && !timer2_counter_select),
        .bypass(timer2_fast_tick),
        .tick(prescale_tick)
    );

    // (R01) (R02) run gate and source select
    assign tick = timer2_run && (timer2_counter_select ? pin_fall : prescale_tick);
    assign t2_overflow = tick && (count == `COUNT_MAX);
    assign wr_low = wr_en && dp_idx == `IDX_T2_LOW;
    assign wr_high = wr_en && dp_idx == `IDX_T2_HIGH;

    // (R04) (R05) hidden reload always takes the write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reload <= `RST_COUNT;
        end else begin
            if (wr_low) begin
                reload[7:0] <= hwdata[7:0];
            end
            if (wr_high) begin
                reload[15:8] <= hwdata[7:0];
            end
        end
    end

    // (R07) counter with auto-reload; writes reach it only while stopped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= `RST_COUNT;
        end else if (timer2_run) begin
            if (t2_overflow) begin
                count <= reload;
            end else if (tick) begin
                count <= count + `COUNT_ONE;
            end
        end else begin
            if (wr_low) begin
                count[7:0] <= hwdata[7:0];
            end
            if (wr_high) begin
                count[15:8] <= hwdata[7:0];
            end
        end
    end

    // Sticky status; an event in the clearing cycle survives
    assign stat_events = {t2_overflow, timer1_overflow, timer0_overflow};
    assign stat_clear = (wr_en && dp_idx == `IDX_IRQ_STATUS) ?
                        hwdata[`STAT_WIDTH-1:0] : `RST_STAT;

    // (R07) request flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= `RST_STAT;
        end else begin
            irq_status <= stat_events | (irq_status & ~stat_clear);
        end
    end

    assign irq = |(irq_status & irq_mask);
    // Clock-output use normally leaves this enable low in software
    assign timer2_irq_request = irq_status[`STAT_T2_OVF] &&
                                interrupt_enable_second[`BIT_ET2];

    // Clock-output channels: 0 timer0, 1 timer1, 2 timer2
    assign chan_ovf = {t2_overflow, timer1_overflow, timer0_overflow};
    assign chan_en = clock_output_and_extint_enable[`CLKO_CHANNELS-1:0];

    genvar ch;
    generate
        for (ch = 0; ch < `CLKO_CHANNELS; ch++) begin : g_clko
            // (R18) (R09) (R10) (R12) (R13) (R15) toggle per overflow halves the rate
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    chan_level[ch] <= 1'b0;
                    chan_oe[ch] <= 1'b0;
                end else begin
                    // (R08) (R11) (R14) enable gates the pin
                    chan_oe[ch] <= chan_en[ch];
                    if (!chan_en[ch]) begin
                        chan_level[ch] <= 1'b0;
                    end else if (chan_ovf[ch]) begin
                        chan_level[ch] <= ~chan_level[ch];
                    end
                end
            end
            AST_CLKO_TOGGLE: assert property ( // R18
                @(posedge hclk) disable iff (!hresetn)
                chan_en[ch] && chan_oe[ch] && chan_ovf[ch]
                |=> chan_level[ch] != $past(chan_level[ch]))
                else $error("clock output did not toggle on overflow");
            AST_CLKO_HOLD: assert property ( // R11
                @(posedge hclk) disable iff (!hresetn)
                chan_en[ch] && !chan_ovf[ch] |=> $stable(chan_level[ch]))
                else $error("clock output moved without overflow");
            AST_CLKO_OFF: assert property ( // R14
                @(posedge hclk) disable iff (!hresetn)
                !chan_en[ch] |=> !chan_oe[ch] && !chan_level[ch])
                else $error("disabled clock output still driven");
        end
    endgenerate

    assign timer0_clk_out = chan_level[`BIT_T0_CLKO];
    assign timer0_clk_oe = chan_oe[`BIT_T0_CLKO];
    assign timer1_clk_out = chan_level[`BIT_T1_CLKO];
    assign timer1_clk_oe = chan_oe[`BIT_T1_CLKO];
    assign timer2_clk_out = chan_level[`BIT_T2_CLKO];
    assign timer2_clk_oe = chan_oe[`BIT_T2_CLKO];

    AST_HOLD_STOPPED: assert property ( // R01
        @(posedge hclk) disable iff (!hresetn)
        !timer2_run && !wr_low && !wr_high |=> count == $past(count))
        else $error("counter moved while stopped");
    AST_COUNT_STEP: assert property ( // R02
        @(posedge hclk) disable iff (!hresetn)
        tick && count != `COUNT_MAX |=> count == $past(count) + `COUNT_ONE)
        else $error("counter did not advance on its tick");
    AST_PIN_ONLY: assert property ( // R02
        @(posedge hclk) disable iff (!hresetn)
        timer2_run && timer2_counter_select && !pin_fall |-> !tick)
        else $error("counter mode ticked without pin edge");
    AST_FAST_PERIOD: assert property ( // R03
        @(posedge hclk) disable iff (!hresetn)
        timer2_run && !timer2_counter_select && timer2_fast_tick |-> tick)
        else $error("fast mode missed a tick");
    AST_STOP_WRITE: assert property ( // R04
        @(posedge hclk) disable iff (!hresetn)
        wr_low && !timer2_run
        |=> count[7:0] == $past(hwdata[7:0]) && reload[7:0] == $past(hwdata[7:0]))
        else $error("stopped write did not load counter and reload");
    AST_RUN_WRITE: assert property ( // R05
        @(posedge hclk) disable iff (!hresetn)
        wr_high && timer2_run && !tick
        |=> count == $past(count) && reload[15:8] == $past(hwdata[7:0]))
        else $error("running write reached the live counter");
    AST_READ_LIVE: assert property ( // R06
        @(posedge hclk) disable iff (!hresetn)
        bus_state == timer2_pkg::BUS_RD_WAIT && dp_idx == `IDX_T2_LOW
        |=> hrdata[7:0] == $past(count[7:0]) && hreadyout)
        else $error("count read did not return live counter");
    AST_OVF_RELOAD: assert property ( // R07
        @(posedge hclk) disable iff (!hresetn)
        t2_overflow && !wr_low && !wr_high
        |=> count == $past(reload) && reload == $past(reload)
            && irq_status[`STAT_T2_OVF])
        else $error("overflow did not reload and flag");
    AST_IE2_RESERVED: assert property ( // R16
        @(posedge hclk) disable iff (!hresetn)
        wr_en && dp_idx == `IDX_IE_SECOND
        |=> interrupt_enable_second == ($past(hwdata[7:0]) & `MASK_IE2))
        else $error("second enable register did not store enables");

    COV_OVERFLOW_CLKO: cover property (
        @(posedge hclk) disable iff (!hresetn)
        t2_overflow && chan_en[`BIT_T2_CLKO]);
    COV_PIN_COUNT: cover property (
        @(posedge hclk) disable iff (!hresetn)
        tick && timer2_counter_select);
    COV_RUN_WRITE: cover property (
        @(posedge hclk) disable iff (!hresetn)
        wr_low && timer2_run);
    COV_IRQ: cover property (
        @(posedge hclk) disable iff (!hresetn)
        irq);
endmodule

// ==== timer2_clkout_tb_top.sv ====
/*
 Self-checking bench for timer2_clkout over AHB-Lite.
 Assumes one slave, so hready is fed back from hreadyout.
*/
`timescale 1ns/100ps
`include "timer2_regs.svh"
module timer2_clkout_tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic t2o, t2e, t0o, t0e, t1o, t1e, f0, f1, t2irq, irq, pin, o0, o1;
    logic [7:0] ie2;
    logic pin_run = 1'b0;
    logic ovf_run = 1'b0;
    int n_mismatch = 0;
    int num_checks = 0;
    logic [31:0] rd;
    int g;

    always #12.5 hclk = ~hclk;

    timer2_clkout u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer2_pin_in(pin),
        .timer0_overflow(o0), .timer1_overflow(o1), .timer2_clk_out(t2o),
        .timer2_clk_oe(t2e), .timer0_clk_out(t0o), .timer0_clk_oe(t0e),
        .timer1_clk_out(t1o), .timer1_clk_oe(t1e), .timer0_fast_tick(f0),
        .timer1_fast_tick(f1), .interrupt_enable_second(ie2),
        .timer2_irq_request(t2irq), .irq(irq));

    pulse_partner u_far (.hclk(hclk), .hresetn(hresetn), .pin_run(pin_run),
        .ovf_run(ovf_run), .timer2_pin_in(pin), .timer0_overflow(o0),
        .timer1_overflow(o1));

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task fail_wait;
        n_mismatch++;
        $display("[ERR] wait expected done seen timeout");
        tally_and_finish;
    endtask

    task wait_rdy;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 50);
        if (hreadyout !== 1'b1) fail_wait;
    endtask

    // Address phase held until hready, then data phase until hready
    task bus(input logic wr, input logic [7:0] ix, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {22'h0, ix, 2'b00};
        hwrite <= wr;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy;
        rd = hrdata;
    endtask

    task rchk(input string what, input logic [7:0] ix, input logic [7:0] exp);
        bus(1'b0, ix, 8'h00);
        check(what, rd, {24'h0, exp});
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    function automatic logic cur(input int s);
        return (s == 0) ? t0o : (s == 1) ? t1o : t2o;
    endfunction

    // Cycles between two successive toggles of one clock output
    task measure(input int sel, output int gap);
        logic last;
        int i;
        last = cur(sel);
        i = 0;
        while (cur(sel) === last && i < 3000) begin
            @(posedge hclk);
            i++;
        end
        last = cur(sel);
        gap = 0;
        while (cur(sel) === last && gap < 3000) begin
            @(posedge hclk);
            gap++;
        end
        if (i >= 3000 || gap >= 3000) fail_wait;
    endtask

    task t_reset;
        static logic [7:0] ix [7] = '{`IDX_AUX_CONTROL, `IDX_CLKOUT_EXTINT, `IDX_IE_SECOND,
            `IDX_T2_HIGH, `IDX_T2_LOW, `IDX_IRQ_STATUS, `IDX_IRQ_MASK};
        for (int k = 0; k < 7; k++) begin
            rchk("reset value", ix[k], (k == 0) ? `RST_AUX : 8'h00);
        end
        $display("test reset done");
    endtask

    task t_regs;
        bus(1'b1, `IDX_IE_SECOND, 8'hff);
        rchk("ie2 read", `IDX_IE_SECOND, 8'h7f);
        check("ie2 port", {24'h0, ie2}, 32'h7f);
        bus(1'b1, `IDX_IE_SECOND, 8'h00);
        rchk("unmapped", 8'h00, 8'h00);
        bus(1'b1, `IDX_AUX_CONTROL, 8'hc0);
        @(posedge hclk);
        check("fast ticks", {30'h0, f0, f1}, 32'h3);
        $display("test regs done");
    endtask

    task t_modes;
        static int mult [3] = '{1, 12, 4};
        static logic [7:0] auxv [3] = '{8'h14, 8'h10, 8'h18};
        for (int m = 0; m < 3; m++) begin
            bus(1'b1, `IDX_AUX_CONTROL, 8'h00);
            bus(1'b1, `IDX_T2_LOW, 8'hf0);
            bus(1'b1, `IDX_T2_HIGH, 8'hff);
            rchk("stopped low", `IDX_T2_LOW, 8'hf0);
            bus(1'b1, `IDX_CLKOUT_EXTINT, 8'h04);
            pin_run <= (m == 2);
            bus(1'b1, `IDX_AUX_CONTROL, auxv[m]);
            measure(2, g);
            check("t2 half period", g, (32'h10000 - 32'hfff0) * mult[m]);
            check("t2 oe", {31'h0, t2e}, 32'h1);
            pin_run <= 1'b0;
        end
        $display("test modes done");
    endtask

    task t_hold;
        bus(1'b1, `IDX_AUX_CONTROL, 8'h00);
        bus(1'b0, `IDX_T2_LOW, 8'h00);
        g = rd;
        repeat (40) @(posedge hclk);
        rchk("held count", `IDX_T2_LOW, g[7:0]);
        bus(1'b1, `IDX_CLKOUT_EXTINT, 8'h00);
        repeat (2) @(posedge hclk);
        check("t2 out off", {30'h0, t2o, t2e}, 32'h0);
        $display("test hold done");
    endtask

    task t_reload;
        bus(1'b1, `IDX_T2_HIGH, 8'h12);
        bus(1'b1, `IDX_T2_LOW, 8'h34);
        bus(1'b1, `IDX_AUX_CONTROL, 8'h10);
        bus(1'b1, `IDX_T2_HIGH, 8'hff);
        bus(1'b1, `IDX_AUX_CONTROL, 8'h00);
        rchk("live high", `IDX_T2_HIGH, 8'h12);
        bus(1'b1, `IDX_T2_LOW, 8'hf0);
        bus(1'b1, `IDX_T2_HIGH, 8'hff);
        bus(1'b1, `IDX_CLKOUT_EXTINT, 8'h04);
        bus(1'b1, `IDX_AUX_CONTROL, 8'h14);
        bus(1'b1, `IDX_T2_LOW, 8'hf8);
        measure(2, g);
        measure(2, g);
        check("new reload span", g, 32'h8);
        bus(1'b1, `IDX_AUX_CONTROL, 8'h00);
        bus(1'b1, `IDX_CLKOUT_EXTINT, 8'h00);
        $display("test reload done");
    endtask

    task t_irq;
        bus(1'b0, `IDX_IRQ_STATUS, 8'h00);
        check("t2 flag", rd & 32'h4, 32'h4);
        check("irq masked", {31'h0, irq}, 32'h0);
        check("t2 request", {31'h0, t2irq}, 32'h0);
        bus(1'b1, `IDX_IE_SECOND, 8'h04);
        @(posedge hclk);
        check("t2 request on", {31'h0, t2irq}, 32'h1);
        bus(1'b1, `IDX_IE_SECOND, 8'h00);
        bus(1'b1, `IDX_IRQ_MASK, 8'h04);
        @(posedge hclk);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        bus(1'b1, `IDX_IRQ_STATUS, 8'h04);
        @(posedge hclk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        bus(1'b0, `IDX_IRQ_STATUS, 8'h00);
        check("flag cleared", rd & 32'h4, 32'h0);
        bus(1'b1, `IDX_IRQ_MASK, 8'h00);
        $display("test irq done");
    endtask

    task t_others;
        ovf_run <= 1'b1;
        bus(1'b1, `IDX_CLKOUT_EXTINT, 8'h03);
        measure(0, g);
        check("t0 half period", g, 32'd10);
        measure(1, g);
        check("t1 half period", g, 32'd6);
        check("t0 t1 oe", {30'h0, t0e, t1e}, 32'h3);
        bus(1'b1, `IDX_CLKOUT_EXTINT, 8'h00);
        ovf_run <= 1'b0;
        repeat (2) @(posedge hclk);
        check("t0 t1 off", {28'h0, t0o, t0e, t1o, t1e}, 32'h0);
        bus(1'b0, `IDX_IRQ_STATUS, 8'h00);
        check("t0 t1 flags", rd & 32'h3, 32'h3);
        bus(1'b1, `IDX_IRQ_STATUS, 8'h03);
        $display("test others done");
    endtask

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_regs;
        t_modes;
        t_hold;
        t_reload;
        t_irq;
        t_others;
        tally_and_finish;
    end
endmodule

// ==== timer2_pkg.sv ====
/*
 Types shared by the timer 2 block.
 Assumes nothing of its surroundings.
*/
package timer2_pkg;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_RD_WAIT = 2'b10
    } bus_state_t;
endpackage

// ==== timer2_regs.svh ====
/*
 Register indices, field positions, reset values and counts for the
 timer 2 reload and clock-output block.
 Assumes the bus address carries the register index in bits 9:2.
*/
`ifndef TIMER2_REGS_SVH
`define TIMER2_REGS_SVH

// Register indices; the byte address is four times the index
`define IDX_AUX_CONTROL 8'h8e
`define IDX_CLKOUT_EXTINT 8'h8f
`define IDX_IE_SECOND 8'haf
`define IDX_T2_HIGH 8'hd6
`define IDX_T2_LOW 8'hd7
`define IDX_IRQ_STATUS 8'he0
`define IDX_IRQ_MASK 8'he1
`define IDX_MSB 9
`define IDX_LSB 2

// Auxiliary control fields
`define BIT_T0_FAST 7
`define BIT_T1_FAST 6
`define BIT_T2_RUN 4
`define BIT_T2_CSEL 3
`define BIT_T2_FAST 2

// Clock-output enable fields, one per channel
`define BIT_T0_CLKO 0
`define BIT_T1_CLKO 1
`define BIT_T2_CLKO 2
`define CLKO_CHANNELS 3

// Second interrupt-enable fields
`define BIT_ET2 2

// Interrupt status / mask layout
`define STAT_T0_OVF 0
`define STAT_T1_OVF 1
`define STAT_T2_OVF 2
`define STAT_WIDTH 3

// Reset values and writable masks
`define RST_AUX 8'h01
`define RST_CLKOUT 8'h00
`define RST_IE2 8'h00
`define RST_COUNT 16'h0000
`define RST_STAT 3'h0
`define MASK_CLKOUT 8'h7f
`define MASK_IE2 8'h7f

// Counting
`define PRESCALE_DIV 12
`define COUNT_MAX 16'hffff
`define COUNT_ONE 16'h0001

`endif
